/* core/wdmpc_top.sv */
// Overview of operation
// R01 - timer interrupt needs enable bit and global enable
// R02 - mode from fuse, reset enable, interrupt enable
// R03 - combined mode: first time-out sets flag
// R04 - vector execution clears enable and flag
// R05 - combined mode: unserviced second time-out resets
// R06 - software re-arms interrupt enable after each interrupt
// R07 - protected fields change only with change enable; the code sets reset enable without it
// R08 - change enable self-clears four cycles later
// R09 - reset cause flag forces reset enable high
// R10 - software clears cause flag before reset enable
// R11 - prescale select from bits five and two-zero
// R12 - base 2048 cycles, doubling up to 1048576
// R13 - reserved prescale codes act as longest period
// R14 - counter advances on separate slow oscillator
// R15 - writing one clears flag, zero keeps it
// R16 - software writes change enable and reset enable together
// R17 - restart command clears the counter
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "wdmpc_params.svh"

module wdmpc_top #(
   parameter int unsigned TIMEOUT_BASE = `WDMPC_TO_BASE
) (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // watchdog pins and processor hooks
   input  wire logic        wd_osc_i,
   input  wire logic        wd_always_on_fuse_i,
   input  wire logic        vector_exec_i,
   output logic             wd_irq_o,
   output logic             sys_reset_o,
   output logic             irq_o
);

   wdmpc_pkg::wdmpc_state_s q_ff;
   wdmpc_pkg::wdmpc_state_s nxt_q;
   wdmpc_pkg::wdmpc_mode_e  mode;
   logic [3:0]              code;
   logic [20:0]             limit;
   logic                    tick;
   logic                    fuse;
   logic                    access;
   logic                    wr;
   logic [7:0]              wd;
   logic                    set_flag;
   logic                    do_rst;
   logic                    new_req;
   logic                    restart;

   // ----------------------------------------------------------------------
   // mode and time-out limit
   // ----------------------------------------------------------------------
   // fuse is a pin level and passes the same two stages as the oscillator
   assign fuse = q_ff.fuse_s2;
   // one-cycle pulse on each rising edge of the synchronised slow oscillator
   assign tick = q_ff.osc_s2 & ~q_ff.osc_d; // see R14

   always_comb begin
      if (fuse) begin
         mode = wdmpc_pkg::WD_RESET; // see R02
      end else begin
         case ({q_ff.re, q_ff.ien})
            2'h0:    mode = wdmpc_pkg::WD_STOPPED;
            2'h1:    mode = wdmpc_pkg::WD_IRQ;
            2'h2:    mode = wdmpc_pkg::WD_RESET;
            2'h3:    mode = wdmpc_pkg::WD_IRQ_RESET; // see R02
            default: mode = wdmpc_pkg::WD_STOPPED;
         endcase
      end
   end

   always_comb begin
      // reserved codes clamp to the longest period
      code = (q_ff.psel > `WDMPC_TO_MAX_CODE) ? `WDMPC_TO_MAX_CODE : q_ff.psel; // see R13
      // a shorter code with the count past the limit times out on the next tick
      limit = 21'(TIMEOUT_BASE) << code; // see R12
   end

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   assign access = wb_cyc_i & wb_stb_i & q_ff.ack;
   assign wr     = access & wb_we_i & wb_sel_i[0];
   assign wd     = wb_dat_i[7:0];
   // request seen for the first time: answered one cycle later
   assign new_req = wb_cyc_i & wb_stb_i & ~q_ff.ack;
   // restart is applied in the counter step so that it wins over a tick
   assign restart = wr & (wb_adr_i == `WDMPC_OFS_CMD) & wd[`WDMPC_BIT_RESTART];

   always_comb begin
      nxt_q = q_ff;
      set_flag = 1'b0;
      do_rst = 1'b0;
      nxt_q.rst_pulse = 1'b0;

      // -------------------------------------------------------------------
      // synchronisers
      // -------------------------------------------------------------------
      nxt_q.osc_s1  = wd_osc_i;
      nxt_q.osc_s2  = q_ff.osc_s1;
      nxt_q.osc_d   = q_ff.osc_s2;
      nxt_q.fuse_s1 = wd_always_on_fuse_i;
      nxt_q.fuse_s2 = q_ff.fuse_s1;

      // -------------------------------------------------------------------
      // bus handshake
      // -------------------------------------------------------------------
      nxt_q.ack = new_req;

      // -------------------------------------------------------------------
      // change enable window
      // -------------------------------------------------------------------
      // the window counts down from the edge that opened it
      if (q_ff.ce) begin
         if (q_ff.ce_cnt == 3'h0) begin
            nxt_q.ce = 1'b0; // see R08
         end else begin
            nxt_q.ce_cnt = q_ff.ce_cnt - 3'h1;
         end
      end

      // -------------------------------------------------------------------
      // register writes
      // -------------------------------------------------------------------
      if (wr) begin
         case (wb_adr_i)
            `WDMPC_OFS_CTRL: begin
               if (wd[`WDMPC_BIT_IFLAG]) begin
                  nxt_q.iflag = 1'b0; // see R15
               end
               nxt_q.ien = wd[`WDMPC_BIT_IEN];
               // opening the window leaves prescale alone
               if (wd[`WDMPC_BIT_CE]) begin
                  nxt_q.ce     = 1'b1;
                  nxt_q.ce_cnt = `WDMPC_CE_CYCLES - 3'h1; // see R08
                  if (wd[`WDMPC_BIT_RE]) begin
                     nxt_q.re = 1'b1;
                  end
               end else begin
                  if (wd[`WDMPC_BIT_RE]) begin
                     nxt_q.re = 1'b1;
                  end else if (q_ff.ce) begin
                     nxt_q.re = 1'b0; // see R07
                  end
                  // prescale loads only inside the open window
                  if (q_ff.ce) begin
                     nxt_q.psel = {wd[`WDMPC_BIT_PS3], wd[2:0]}; // see R07, R11
                     nxt_q.ce   = 1'b0;
                  end
               end
            end
            `WDMPC_OFS_IRQ_STS: begin
               nxt_q.sts = q_ff.sts & ~wd[1:0];
            end
            `WDMPC_OFS_IRQ_MSK: begin
               nxt_q.msk = wd[1:0];
            end
            `WDMPC_OFS_CAUSE: begin
               if (!wd[`WDMPC_BIT_CAUSE]) begin
                  nxt_q.cause = 1'b0;
               end
            end
            `WDMPC_OFS_CMD: begin
               nxt_q.gie = wd[`WDMPC_BIT_GIE];
            end
            default: begin
            end
         endcase
      end

      // -------------------------------------------------------------------
      // interrupt vector taken by the processor
      // -------------------------------------------------------------------
      if (vector_exec_i) begin
         nxt_q.ien   = 1'b0; // see R04
         nxt_q.iflag = 1'b0; // see R04
      end

      // -------------------------------------------------------------------
      // counter and time-out
      // -------------------------------------------------------------------
      if (restart) begin
         nxt_q.cnt = 20'h00000; // see R17
      end else if (tick && mode != wdmpc_pkg::WD_STOPPED) begin
         if ({1'b0, q_ff.cnt} >= limit - 21'h000001) begin
            nxt_q.cnt = 20'h00000;
            case (mode)
               wdmpc_pkg::WD_IRQ: begin
                  set_flag = 1'b1;
               end
               wdmpc_pkg::WD_RESET: begin
                  do_rst = 1'b1;
               end
               wdmpc_pkg::WD_IRQ_RESET: begin
                  if (q_ff.iflag) begin
                     do_rst = 1'b1; // see R05
                  end else begin
                     set_flag = 1'b1; // see R03
                  end
               end
               default: begin
               end
            endcase
         end else begin
            nxt_q.cnt = q_ff.cnt + 20'h00001;
         end
      end

      // -------------------------------------------------------------------
      // events win over clears in the same cycle
      // -------------------------------------------------------------------
      if (set_flag) begin
         nxt_q.iflag = 1'b1;
         nxt_q.sts[`WDMPC_EV_IRQ] = 1'b1;
      end
      // internal emulation of the system reset being requested
      if (do_rst) begin
         nxt_q.rst_pulse = 1'b1;
         nxt_q.cause     = 1'b1;
         nxt_q.ien       = 1'b0;
         nxt_q.iflag     = 1'b0;
         nxt_q.ce        = 1'b0;
         nxt_q.psel      = `WDMPC_RST_PSEL;
         nxt_q.sts[`WDMPC_EV_RST] = 1'b1;
      end

      // -------------------------------------------------------------------
      // overrides of reset enable
      // -------------------------------------------------------------------
      if (nxt_q.cause) begin
         nxt_q.re = 1'b1; // see R09
      end
      if (fuse) begin
         nxt_q.re  = 1'b1; // see R02
         nxt_q.ien = 1'b0;
      end

      // -------------------------------------------------------------------
      // read data
      // -------------------------------------------------------------------
      // read data is registered and stands with the acknowledge
      if (new_req) begin
         case (wb_adr_i)
            `WDMPC_OFS_CTRL: begin
               nxt_q.rdata = {24'h000000, q_ff.iflag, q_ff.ien, q_ff.psel[3], q_ff.ce,
                              q_ff.re, q_ff.psel[2:0]};
            end
            `WDMPC_OFS_IRQ_STS: begin
               nxt_q.rdata = {30'h00000000, q_ff.sts};
            end
            `WDMPC_OFS_IRQ_MSK: begin
               nxt_q.rdata = {30'h00000000, q_ff.msk};
            end
            `WDMPC_OFS_CAUSE: begin
               nxt_q.rdata = {31'h00000000, q_ff.cause};
            end
            `WDMPC_OFS_CMD: begin
               nxt_q.rdata = {31'h00000000, q_ff.gie};
            end
            default: begin
               nxt_q.rdata = 32'h00000000;
            end
         endcase
      end

      // -------------------------------------------------------------------
      // synchronous reset
      // -------------------------------------------------------------------
      // prescale and event bits restart from their reset values
      if (reset_i) begin
         nxt_q = '0;
         nxt_q.psel = `WDMPC_RST_PSEL;
         nxt_q.sts  = `WDMPC_RST_EV;
         nxt_q.msk  = `WDMPC_RST_EV;
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      q_ff <= nxt_q;
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign wb_ack_o    = q_ff.ack;
   assign wb_dat_o    = q_ff.rdata;
   assign wd_irq_o    = q_ff.iflag & q_ff.ien & q_ff.gie; // see R01
   // the block's own state is not reset by its request; it is emulated inside
   assign sys_reset_o = q_ff.rst_pulse;
   assign irq_o       = |(q_ff.sts & q_ff.msk);

endmodule

/* include/wdmpc_params.svh */
`ifndef WDMPC_PARAMS_SVH
`define WDMPC_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define WDMPC_OFS_CTRL      5'h00
`define WDMPC_OFS_IRQ_STS   5'h04
`define WDMPC_OFS_IRQ_MSK   5'h08
`define WDMPC_OFS_CAUSE     5'h0C
`define WDMPC_OFS_CMD       5'h10

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define WDMPC_BIT_IFLAG     7
`define WDMPC_BIT_IEN       6
`define WDMPC_BIT_PS3       5
`define WDMPC_BIT_CE        4
`define WDMPC_BIT_RE        3
`define WDMPC_BIT_CAUSE     0
`define WDMPC_BIT_GIE       0
`define WDMPC_BIT_RESTART   1
`define WDMPC_EV_IRQ        0
`define WDMPC_EV_RST        1

// ----------------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------------
`define WDMPC_RST_PSEL      4'h0
`define WDMPC_RST_EV        2'h0
`define WDMPC_CE_CYCLES     3'h4
`define WDMPC_TO_BASE       2048
`define WDMPC_TO_MAX_CODE   4'h9
`define WDMPC_OSC_KHZ       128

`endif

/* include/wdmpc_pkg.sv */
package wdmpc_pkg;

   typedef enum logic [1:0] {
      WD_STOPPED,
      WD_IRQ,
      WD_RESET,
      WD_IRQ_RESET
   } wdmpc_mode_e;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
      logic        ien;
      logic        iflag;
      logic        ce;
      logic [2:0]  ce_cnt;
      logic        re;
      logic [3:0]  psel;
      logic        gie;
      logic        cause;
      logic [19:0] cnt;
      logic        osc_s1;
      logic        osc_s2;
      logic        osc_d;
      logic        fuse_s1;
      logic        fuse_s2;
      logic [1:0]  sts;
      logic [1:0]  msk;
      logic        rst_pulse;
   } wdmpc_state_s;

endpackage

/* sim/wdmpc_props.sv */
`timescale 1ns/100ps
`include "wdmpc_params.svh"
module wdmpc_props (
   // clock, reset and bus
   input wire logic        sys_clk_i,
   input wire logic        reset_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [4:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // watchdog
   input wire logic        wd_always_on_fuse_i,
   input wire logic        vector_exec_i,
   input wire logic        wd_irq_o,
   input wire logic        sys_reset_o,
   input wire logic        irq_o
);
   // ---------------------------------
   // properties
   // ---------------------------------
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_wr(logic [4:0] a);
      s_req ##0 wb_we_i && wb_sel_i[0] && wb_adr_i == a;
   endsequence
   property p_ack;
      s_req |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("bad ack");
   property p_unm;
      s_req ##0 !wb_we_i && wb_adr_i > 5'h10 |=> wb_dat_o == 32'h0;
   endproperty
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
   property p_rst;
      sys_reset_o |=> !sys_reset_o && !wd_irq_o;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset pulse");
   property p_vec;
      vector_exec_i |-> ##2 !wd_irq_o [*2];
   endproperty
   a_vec: assert property (p_vec) else $error("vector kept irq");
   property p_gie;
      s_wr(`WDMPC_OFS_CMD) ##0 !wb_dat_i[0] |-> ##3 !wd_irq_o;
   endproperty
   a_gie: assert property (p_gie) else $error("irq without gie");
   property p_w1c;
      s_wr(`WDMPC_OFS_CTRL) ##0 wb_dat_i[7] |-> ##3 !wd_irq_o;
   endproperty
   a_w1c: assert property (p_w1c) else $error("flag not cleared");
   property p_fuse;
      wd_always_on_fuse_i [*6] |-> !wd_irq_o;
   endproperty
   a_fuse: assert property (p_fuse) else $error("irq with fuse");
   property p_msk;
      s_wr(`WDMPC_OFS_IRQ_MSK) ##0 wb_dat_i[1:0] == 2'h0 |-> ##3 !irq_o;
   endproperty
   a_msk: assert property (p_msk) else $error("masked irq seen");
endmodule
bind wdmpc_top wdmpc_props u_props (.sys_clk_i, .reset_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
   .wd_always_on_fuse_i, .vector_exec_i, .wd_irq_o, .sys_reset_o, .irq_o);

/* sim/wdmpc_top_tb.sv */
`timescale 1ns/100ps
`include "wdmpc_params.svh"
module wdmpc_top_tb;
   localparam logic [4:0] C = `WDMPC_OFS_CTRL;
   logic        clk, rst, cyc, stb, we, osc, fuse, vec;
   logic        ack, wirq, srst, irq;
   logic [4:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, q;
   int          error_cnt, checks_done, rst_cnt;

   wdmpc_top #(.TIMEOUT_BASE(4)) DUT (
      .sys_clk_i(clk), .reset_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .wd_osc_i(osc),
      .wd_always_on_fuse_i(fuse), .vector_exec_i(vec), .wd_irq_o(wirq),
      .sys_reset_o(srst), .irq_o(irq));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (srst === 1'b1) rst_cnt++;
   // ---------------------------------
   // tasks
   // ---------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic cb(input string n, input logic e, input logic g);
      @(posedge clk);
      chk(n, {31'h0, e}, {31'h0, g});
   endtask
   task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic rc(input string n, input logic [4:0] a, input logic [31:0] e);
      bus(a, 1'b0, 8'h00);
      chk(n, e, q);
   endtask
   task automatic prot(input logic [7:0] d);
      wr(C, 8'h18);
      wr(C, d);
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         osc <= 1'b1;
         repeat (3) @(posedge clk);
         osc <= 1'b0;
         repeat (3) @(posedge clk);
      end
      repeat (4) @(posedge clk);
   endtask
   task automatic print_verdict();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      print_verdict();
   end
   initial begin
      rst = 1'b1;
      {cyc, stb, we, osc, fuse, vec} = 6'h00;
      adr = 5'h00;
      sel = 4'h1;
      wdat = 32'h0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rc("ctrl", C, 32'h00);
      rc("unmapped", 5'h14, 32'h00);
      wr(C, 8'h0D);
      rc("ctrl", C, 32'h08);
      wr(C, 8'h00);
      rc("ctrl", C, 32'h08);
      prot(8'h05);
      rc("ctrl", C, 32'h05);
      prot(8'h20);
      rc("ctrl", C, 32'h20);
      wr(C, 8'h18);
      repeat (6) @(posedge clk);
      wr(C, 8'h00);
      rc("ctrl", C, 32'h28);
      prot(8'h40);
      wr(`WDMPC_OFS_IRQ_MSK, 8'h03);
      wr(`WDMPC_OFS_CMD, 8'h03);
      tick(3);
      wr(`WDMPC_OFS_CMD, 8'h03);
      tick(3);
      cb("wd_irq", 1'b0, wirq);
      tick(1);
      cb("wd_irq", 1'b1, wirq);
      cb("irq", 1'b1, irq);
      rc("ctrl", C, 32'hC0);
      wr(C, 8'h40);
      rc("ctrl", C, 32'hC0);
      wr(C, 8'hC0);
      rc("ctrl", C, 32'h40);
      wr(`WDMPC_OFS_IRQ_STS, 8'h01);
      cb("irq", 1'b0, irq);
      wr(C, 8'h48);
      wr(`WDMPC_OFS_CMD, 8'h03);
      tick(4);
      cb("wd_irq", 1'b1, wirq);
      chk("resets", 32'h0, rst_cnt);
      vec <= 1'b1;
      @(posedge clk);
      vec <= 1'b0;
      rc("ctrl", C, 32'h08);
      wr(C, 8'h48);
      wr(`WDMPC_OFS_CMD, 8'h03);
      tick(8);
      chk("resets", 32'h1, rst_cnt);
      rc("cause", `WDMPC_OFS_CAUSE, 32'h01);
      prot(8'h00);
      rc("ctrl", C, 32'h08);
      wr(`WDMPC_OFS_CAUSE, 8'h00);
      prot(8'h00);
      rc("ctrl", C, 32'h00);
      prot(8'h62);
      wr(`WDMPC_OFS_CMD, 8'h03);
      tick(2047);
      cb("wd_irq", 1'b0, wirq);
      tick(1);
      cb("wd_irq", 1'b1, wirq);
      wr(`WDMPC_OFS_CMD, 8'h00);
      cb("wd_irq", 1'b0, wirq);
      sel <= 4'h0;
      wr(`WDMPC_OFS_IRQ_MSK, 8'h00);
      sel <= 4'h1;
      rc("msk", `WDMPC_OFS_IRQ_MSK, 32'h03);
      wr(`WDMPC_OFS_IRQ_MSK, 8'h00);
      cb("irq", 1'b0, irq);
      fuse <= 1'b1;
      repeat (8) @(posedge clk);
      rc("ctrl", C, 32'hAA);
      wr(`WDMPC_OFS_CMD, 8'h01);
      cb("wd_irq", 1'b0, wirq);
      print_verdict();
   end
endmodule
